//--- include/tasl_map.vh
// Purpose: constants for the temperature alarm and standby logic
// Assumes: registers reached through a simple byte write/read port behind the serial bus framing
// Notes: none
// Notes on behaviour
// - config bit 6 set means standby; conversion aborted, no result stored.
// - register port keeps working during standby.
// - one-shot write in standby converts both channels once, then standby again.
// - data byte written to one-shot register is ignored.
// - limit writes in standby re-check stored values and may raise alarm.
// - open-sensor comparator sampled at conversion start sets status bit 2.
// - open flag pulls alarm low when alarm output enabled.
// - alarm output maskable; primary trip output never masked.
// - alarm when temperature above high limit or at/below low limit.
// - alarm released after alert response read, condition gone, status cleared.
// - trip output low when a channel exceeds its trip limit.
// - trip released at trip limit minus hysteresis, per channel, automatically.
// - hysteresis resets to 10 degrees, unsigned whole degrees, reprogrammable.
// - alarm pin selectable as alarm or second trip output.
// - second trip low above high limit, unmaskable, hysteresis release.
// - second trip uses same hysteresis value.
// - signed offset added to every measurement before storing.
// - alert response read answers own seven-bit address plus trailing one.
// - alarm output open-drain, only pulls low.
`ifndef TASL_MAP_VH
`define TASL_MAP_VH
`define TASL_A_LOC_VAL 8'h00
`define TASL_A_REM_VAL 8'h01
`define TASL_A_STATUS 8'h02
`define TASL_A_CONFIG 8'h03
`define TASL_A_LOC_HI 8'h05
`define TASL_A_LOC_LO 8'h06
`define TASL_A_REM_HI 8'h07
`define TASL_A_REM_LO 8'h08
`define TASL_A_ONESHOT 8'h0F
`define TASL_A_OFFSET 8'h11
`define TASL_A_REM_TRIP 8'h19
`define TASL_A_LOC_TRIP 8'h20
`define TASL_A_HYST 8'h21
`define TASL_A_STAT_CLR 8'h22
`define TASL_CFG_MASK_BIT 7
`define TASL_CFG_STBY_BIT 6
`define TASL_CFG_PIN2_BIT 5
`define TASL_ST_BUSY 7
`define TASL_ST_LHI 6
`define TASL_ST_LLO 5
`define TASL_ST_RHI 4
`define TASL_ST_RLO 3
`define TASL_ST_OPEN 2
`define TASL_ST_RTRIP 1
`define TASL_ST_LTRIP 0
`define TASL_HYST_RST 8'h0A
`define TASL_HI_RST 8'h55
`define TASL_LO_RST 8'h00
`define TASL_TRIP_RST 8'h55
`define TASL_CONV_CYC 16'h0FA0
`endif

//--- hw/tasl_core.v
// Purpose: standby, one-shot, open-sensor, alarm and trip output logic
// Assumes: analog result valid when convert done pulses, open comparator valid at conversion start
// Notes: temperatures are signed 8-bit whole degrees
`timescale 1ns/1ps
`default_nettype none
`include "tasl_map.vh"
module tasl_core #(
  parameter [15:0] CONV_CYC = `TASL_CONV_CYC,
  parameter [6:0] DEV_ADDR = 7'h2A
)(
  input wire I_SYS_CLK,
  input wire I_RST_B,
  input wire I_WR,
  input wire I_RD,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  output reg [7:0] O_RDATA,
  input wire I_ARA_RD,
  output reg [7:0] O_ARA_DATA,
  output reg O_ARA_ACK,
  input wire I_OPEN_CMP,
  input wire [7:0] I_ADC_LOC,
  input wire [7:0] I_ADC_REM,
  output wire O_CONV_RUN,
  output wire O_ALERT_O,
  output wire O_ALERT_OE_B,
  output wire O_TRIP_O,
  output wire O_TRIP_OE_B
);
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  reg [7:0] cfg_q, hyst_q, off_q, lhi_q, llo_q, rhi_q, rlo_q, ltrip_q, rtrip_q;
  reg [7:0] lval_q, rval_q, stat_q;
  reg [15:0] cnt_q;
  reg run_q, shot_q, alert_q, trip_q, t2_q, ltr_q, rtr_q, lt2_q, rt2_q, oneshot_conv_q, vld_q;
  wire stby = cfg_q[`TASL_CFG_STBY_BIT];
  wire pin2 = cfg_q[`TASL_CFG_PIN2_BIT];

  function [7:0] sat_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7])
        sat_add = s[8] ? 8'h80 : 8'h7F;
      else
        sat_add = s[7:0];
    end
  endfunction

  function gt;
    input [7:0] a;
    input [7:0] b;
    begin
      gt = $signed(a) > $signed(b);
    end
  endfunction

  // hysteresis release point, saturated at the bottom of the range
  function [7:0] rel_pt;
    input [7:0] lim;
    input [7:0] h;
    reg [9:0] s;
    begin
      // a full 8-bit hysteresis can reach below -256, so one guard bit is not enough
      s = {{2{lim[7]}}, lim} - {2'b00, h};
      if (s[9] && (s[8:7] != 2'b11))
        rel_pt = 8'h80;
      else
        rel_pt = s[7:0];
    end
  endfunction

  // no limit verdict before a first result is stored, else reset values would alarm
  wire lhi = vld_q & gt(lval_q, lhi_q);
  wire rhi = vld_q & gt(rval_q, rhi_q);
  // at or below low limit counts as a violation
  wire llo = vld_q & !gt(lval_q, llo_q);
  wire rlo = vld_q & !gt(rval_q, rlo_q);
  wire conv_done = run_q && (cnt_q == 16'h0001);
  wire start = !run_q && (!stby || shot_q);
  wire clr = I_WR && (I_ADDR == `TASL_A_STAT_CLR);
  wire [7:0] ladj = sat_add(I_ADC_LOC, off_q);
  wire [7:0] radj = sat_add(I_ADC_REM, off_q);

  // ---------------------------------------------
  // register writes
  // ---------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      cfg_q <= 8'h00;
      hyst_q <= `TASL_HYST_RST;
      off_q <= 8'h00;
      lhi_q <= `TASL_HI_RST;
      rhi_q <= `TASL_HI_RST;
      llo_q <= `TASL_LO_RST;
      rlo_q <= `TASL_LO_RST;
      ltrip_q <= `TASL_TRIP_RST;
      rtrip_q <= `TASL_TRIP_RST;
    end
    else if (I_WR)
    begin
      if (I_ADDR == `TASL_A_CONFIG)
        cfg_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_HYST)
        hyst_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_OFFSET)
        off_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_LOC_HI)
        lhi_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_LOC_LO)
        llo_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_REM_HI)
        rhi_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_REM_LO)
        rlo_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_LOC_TRIP)
        ltrip_q <= I_WDATA;
      else if (I_ADDR == `TASL_A_REM_TRIP)
        rtrip_q <= I_WDATA;
    end
  end

  // ---------------------------------------------
  // conversion control
  // ---------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      run_q <= 1'b0;
      shot_q <= 1'b0;
      cnt_q <= 16'h0000;
      lval_q <= 8'h00;
      rval_q <= 8'h00;
      vld_q <= 1'b0;
    end
    else
    begin
      if (I_WR && (I_ADDR == `TASL_A_ONESHOT) && stby)
        shot_q <= 1'b1;
      else if (start)
        shot_q <= 1'b0;
      if (start)
      begin
        run_q <= 1'b1;
        cnt_q <= CONV_CYC;
      end
      else if (run_q && stby && !oneshot_conv_q)
        run_q <= 1'b0;
      else if (run_q)
      begin
        cnt_q <= cnt_q - 16'h0001;
        if (conv_done)
        begin
          run_q <= 1'b0;
          vld_q <= 1'b1;
          lval_q <= ladj;
          rval_q <= radj;
        end
      end
    end
  end

  // remembers that the running conversion came from a one-shot
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      oneshot_conv_q <= 1'b0;
    else if (start)
      oneshot_conv_q <= stby;
    else if (!run_q)
      oneshot_conv_q <= 1'b0;
  end

  // ---------------------------------------------
  // status flags, set wins over clear
  // ---------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      stat_q <= 8'h00;
    else
    begin
      stat_q[`TASL_ST_LHI] <= lhi | (stat_q[`TASL_ST_LHI] & !clr);
      stat_q[`TASL_ST_LLO] <= llo | (stat_q[`TASL_ST_LLO] & !clr);
      stat_q[`TASL_ST_RHI] <= rhi | (stat_q[`TASL_ST_RHI] & !clr);
      stat_q[`TASL_ST_RLO] <= rlo | (stat_q[`TASL_ST_RLO] & !clr);
      stat_q[`TASL_ST_OPEN] <= (start & I_OPEN_CMP) | (stat_q[`TASL_ST_OPEN] & !clr);
      stat_q[`TASL_ST_RTRIP] <= rtr_q;
      stat_q[`TASL_ST_LTRIP] <= ltr_q;
      stat_q[`TASL_ST_BUSY] <= run_q;
    end
  end

  // ---------------------------------------------
  // trip outputs with hysteresis
  // ---------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      ltr_q <= 1'b0;
      rtr_q <= 1'b0;
      lt2_q <= 1'b0;
      rt2_q <= 1'b0;
    end
    else
    begin
      ltr_q <= gt(lval_q, ltrip_q) | (ltr_q & gt(lval_q, rel_pt(ltrip_q, hyst_q)));
      rtr_q <= gt(rval_q, rtrip_q) | (rtr_q & gt(rval_q, rel_pt(rtrip_q, hyst_q)));
      lt2_q <= lhi | (lt2_q & gt(lval_q, rel_pt(lhi_q, hyst_q)));
      rt2_q <= rhi | (rt2_q & gt(rval_q, rel_pt(rhi_q, hyst_q)));
    end
  end

  // ---------------------------------------------
  // alarm latch and alert response
  // ---------------------------------------------
  wire cause = lhi | llo | rhi | rlo;
  wire any_stat = |stat_q[6:2];
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      alert_q <= 1'b0;
      O_ARA_ACK <= 1'b0;
      O_ARA_DATA <= 8'h00;
    end
    else
    begin
      O_ARA_ACK <= 1'b0;
      // answer address plus one while the alarm is live
      if (I_ARA_RD && alert_q && !pin2 && !cfg_q[`TASL_CFG_MASK_BIT])
      begin
        O_ARA_ACK <= 1'b1;
        O_ARA_DATA <= {DEV_ADDR, 1'b1};
      end
      if (cause | stat_q[`TASL_ST_OPEN])
        alert_q <= 1'b1;
      // release only when answered and clean
      else if (I_ARA_RD && alert_q && !pin2 && !cfg_q[`TASL_CFG_MASK_BIT] && !any_stat && !clr)
        alert_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // read path and pins
  // ---------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
      O_RDATA <= 8'h00;
    else if (I_RD)
    begin
      if (I_ADDR == `TASL_A_LOC_VAL)
        O_RDATA <= lval_q;
      else if (I_ADDR == `TASL_A_REM_VAL)
        O_RDATA <= rval_q;
      else if (I_ADDR == `TASL_A_STATUS)
        O_RDATA <= stat_q;
      else if (I_ADDR == `TASL_A_CONFIG)
        O_RDATA <= cfg_q;
      else if (I_ADDR == `TASL_A_HYST)
        O_RDATA <= hyst_q;
      else if (I_ADDR == `TASL_A_OFFSET)
        O_RDATA <= off_q;
      else
        O_RDATA <= 8'h00;
    end
  end

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RST_B)
    begin
      trip_q <= 1'b0;
      t2_q <= 1'b0;
    end
    else
    begin
      trip_q <= ltr_q | rtr_q;
      t2_q <= pin2 ? (lt2_q | rt2_q) : (alert_q & !cfg_q[`TASL_CFG_MASK_BIT]);
    end
  end

  assign O_CONV_RUN = run_q;
  assign O_ALERT_O = 1'b0;
  assign O_ALERT_OE_B = !t2_q;
  assign O_TRIP_O = 1'b0;
  assign O_TRIP_OE_B = !trip_q;
endmodule // tasl_core
`default_nettype wire

//--- tb/tasl_core_properties.sv
// Purpose: port checks for tasl_core
// Assumes: one clock, sync active-low reset
// Notes: both pins are open drain
`timescale 1ns/1ps
`default_nettype none
module tasl_chk #(
  parameter [6:0] DEV_ADDR = 7'h2A
)(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_RD,
  input wire logic I_ARA_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [7:0] O_ARA_DATA,
  input wire logic O_ARA_ACK,
  input wire logic O_ALERT_O,
  input wire logic O_ALERT_OE_B,
  input wire logic O_TRIP_O,
  input wire logic O_TRIP_OE_B
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_ask;
    I_ARA_RD ##1 O_ARA_ACK;
  endsequence
  AST_ARA_ADDR: assert property (s_ask |-> O_ARA_DATA == {DEV_ADDR, 1'b1})
    else $error("wrong alert answer");
  AST_ARA_CAUSE: assert property (O_ARA_ACK |-> $past(I_ARA_RD))
    else $error("answer without request");
  AST_ARA_LIVE: assert property (O_ARA_ACK |-> !O_ALERT_OE_B)
    else $error("answer while alert idle");
  AST_ACK_ONE: assert property (O_ARA_ACK && !I_ARA_RD |=> !O_ARA_ACK)
    else $error("answer longer than one cycle");
  AST_ALERT_OD: assert property (!O_ALERT_O)
    else $error("alert pin driven high");
  AST_TRIP_OD: assert property (!O_TRIP_O)
    else $error("trip pin driven high");
  AST_RDATA_HOLD: assert property ($past(I_RST_B) && !$past(I_RD) |-> $stable(O_RDATA))
    else $error("read data moved without read");
  AST_RST_REL: assert property ($rose(I_RST_B) |-> O_ALERT_OE_B && O_TRIP_OE_B && O_RDATA == 8'h00)
    else $error("pins not released after reset");
endmodule // tasl_chk
bind tasl_core tasl_chk #(.DEV_ADDR(DEV_ADDR)) u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_RD(I_RD),
  .I_ARA_RD(I_ARA_RD), .O_RDATA(O_RDATA), .O_ARA_DATA(O_ARA_DATA), .O_ARA_ACK(O_ARA_ACK), .O_ALERT_O(O_ALERT_O),
  .O_ALERT_OE_B(O_ALERT_OE_B), .O_TRIP_O(O_TRIP_O), .O_TRIP_OE_B(O_TRIP_OE_B));
`default_nettype wire

//--- tb/tasl_host_model.sv
// Purpose: host side of the alert and trip lines
// Assumes: external pull-ups on both lines
// Notes: any device pulling low wins
`timescale 1ns/1ps
`default_nettype none
module tasl_host_model (
  input wire logic i_alert,
  input wire logic i_alert_oe_b,
  input wire logic i_trip,
  input wire logic i_trip_oe_b,
  output logic o_alert_line,
  output logic o_trip_line
);
  assign o_alert_line = i_alert_oe_b ? 1'b1 : i_alert;
  assign o_trip_line = i_trip_oe_b ? 1'b1 : i_trip;
endmodule // tasl_host_model
`default_nettype wire

//--- tb/test_temp_alarm_standby_logic.sv
// Purpose: directed test of tasl_core
// Assumes: conversion shortened to 8 cycles
// Notes: stimulus changes on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_temp_alarm_standby_logic;
  // arbitrary bus address
  localparam logic [6:0] DEV_A = 7'h2A;
  logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ara_s = 1'b0, open_cmp = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, adc_loc = 8'h20, adc_rem = 8'h30;
  wire logic [7:0] rdata, ara_data;
  wire logic ara_ack, run, al_o, al_oe_b, tr_o, tr_oe_b, al_line, tr_line;
  int bad_count = 0, cmp_count = 0;
  tasl_core #(.CONV_CYC(16'h0008), .DEV_ADDR(DEV_A)) DUT (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_WR(wr_s),
    .I_RD(rd_s), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .I_ARA_RD(ara_s), .O_ARA_DATA(ara_data),
    .O_ARA_ACK(ara_ack), .I_OPEN_CMP(open_cmp), .I_ADC_LOC(adc_loc), .I_ADC_REM(adc_rem), .O_CONV_RUN(run),
    .O_ALERT_O(al_o), .O_ALERT_OE_B(al_oe_b), .O_TRIP_O(tr_o), .O_TRIP_OE_B(tr_oe_b));
  tasl_host_model u_host (.i_alert(al_o), .i_alert_oe_b(al_oe_b), .i_trip(tr_o), .i_trip_oe_b(tr_oe_b),
    .o_alert_line(al_line), .o_trip_line(tr_line));
  initial forever #20 clk = ~clk;
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_s = 1'b1;
    addr = a;
    @(negedge clk);
    rd_s = 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // ack may land one or two edges after the request
  task automatic ara_rd(input logic exp);
    logic seen;
    logic [7:0] d;
    seen = 1'b0;
    d = 8'h00;
    @(negedge clk);
    ara_s = 1'b1;
    @(negedge clk);
    ara_s = 1'b0;
    repeat (2)
    begin
      if (ara_ack === 1'b1)
      begin
        seen = 1'b1;
        d = ara_data;
      end
      @(negedge clk);
    end
    chk({7'h00, seen}, {7'h00, exp});
    if (exp)
      chk(d, {DEV_A, 1'b1});
  endtask
  task automatic pin(input logic a, input logic t);
    for (int i = 0; i < 8 && {al_line, tr_line} !== {a, t}; i++)
      @(negedge clk);
    chk({6'h00, al_line, tr_line}, {6'h00, a, t});
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 64 && run !== v; i++)
      @(negedge clk);
    if (run !== v)
    begin
      bad_count++;
      $display("BAD %0t conversion wait ran out", $time);
      results();
    end
    else
      chk({7'h00, run}, {7'h00, v});
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    reg_rd(8'h21, 8'h0A);
    reg_rd(8'h44, 8'h00);
    reg_wr(8'h21, 8'h05);
    reg_rd(8'h21, 8'h05);
    reg_wr(8'h11, 8'h02);
    reg_wr(8'h03, 8'h40);
    wait_run(1'b0);
    $display("test 1 done");
    reg_wr(8'h0F, 8'hA5);
    wait_run(1'b1);
    wait_run(1'b0);
    repeat (12) @(negedge clk);
    chk({7'h00, run}, 8'h00);
    reg_rd(8'h00, 8'h22);
    reg_rd(8'h01, 8'h32);
    pin(1'b1, 1'b1);
    $display("test 2 done");
    reg_wr(8'h05, 8'h10);
    pin(1'b0, 1'b1);
    reg_rd(8'h02, 8'h40);
    ara_rd(1'b1);
    pin(1'b0, 1'b1);
    reg_wr(8'h05, 8'h55);
    reg_wr(8'h22, 8'hFF);
    pin(1'b0, 1'b1);
    ara_rd(1'b1);
    pin(1'b1, 1'b1);
    ara_rd(1'b0);
    $display("test 3 done");
    reg_wr(8'h03, 8'hC0);
    reg_wr(8'h05, 8'h20);
    reg_wr(8'h20, 8'h21);
    pin(1'b1, 1'b0);
    reg_wr(8'h20, 8'h26);
    pin(1'b1, 1'b0);
    reg_wr(8'h20, 8'h27);
    pin(1'b1, 1'b1);
    reg_wr(8'h03, 8'hE0);
    pin(1'b0, 1'b1);
    reg_wr(8'h05, 8'h26);
    pin(1'b0, 1'b1);
    reg_wr(8'h05, 8'h27);
    pin(1'b1, 1'b1);
    $display("test 4 done");
    reg_wr(8'h05, 8'h55);
    reg_wr(8'h03, 8'h40);
    reg_wr(8'h22, 8'hFF);
    ara_rd(1'b1);
    pin(1'b1, 1'b1);
    open_cmp = 1'b1;
    reg_wr(8'h0F, 8'h00);
    wait_run(1'b1);
    wait_run(1'b0);
    reg_rd(8'h02, 8'h04);
    pin(1'b0, 1'b1);
    $display("test 5 done");
    open_cmp = 1'b0;
    adc_loc = 8'h50;
    reg_wr(8'h03, 8'h00);
    wait_run(1'b1);
    reg_wr(8'h03, 8'h40);
    @(negedge clk);
    chk({7'h00, run}, 8'h00);
    reg_rd(8'h00, 8'h22);
    $display("test 6 done");
    results();
  end
endmodule // test_temp_alarm_standby_logic
`default_nettype wire
